/* File: hdl/cfs_pkg.sv */
package cfs_pkg;

   // register indices on the plain register port
   localparam logic [7:0] OFS_FLAGS   = 8'h00;
   localparam logic [7:0] OFS_ISTAT   = 8'h01;
   localparam logic [7:0] OFS_IMASK   = 8'h02;

   // processor_flags field positions
   localparam int         PAGE_LSB    = 5;
   localparam int         WD_BIT      = 4;
   localparam int         BO_BIT      = 3;
   localparam int         Z_BIT       = 2;
   localparam int         DC_BIT      = 1;
   localparam int         C_BIT       = 0;

   // interrupt status / mask layout
   localparam int         EV_CARRY    = 0;
   localparam int         EV_ZERO     = 1;
   localparam int         EV_PAGE     = 2;
   localparam int         EV_W        = 3;

   localparam int         JADDR_W     = 13;
   localparam int         TADDR_W     = 16;

   // values after reset
   localparam logic [2:0] PAGE_RST    = 3'h0;
   localparam logic [2:0] EVT_RST     = 3'h0;
   localparam logic [7:0] RDATA_RST   = 8'h00;
   localparam logic [15:0] TADDR_RST  = 16'h0000;

   typedef enum logic [2:0]
   {
      OP_NONE,
      OP_ADD,
      OP_SUB,
      OP_RR,
      OP_RL,
      OP_LOGIC
   } cfs_op_t;

endpackage

/* File: hdl/cfs_status.sv */
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
// Contract
// - The page field forms the top of the jump/call target above the 13-bit instruction address.
// - The page instruction loads the page field with the value it carries.
// - At reset the watchdog flag is set when a watchdog overflow caused it, else cleared.
// - At reset the brown-out flag is set when low-voltage detection caused it, else cleared.
// - A zero-affecting instruction sets the zero flag on a zero result and clears it otherwise.
// - The zero flag is updated only when decode raises the per-instruction zero enable; a software write to OFS_FLAGS also loads it.
// - After an addition the nibble flag shows the carry out of bit 3.
// - After a subtraction the nibble flag is cleared on a borrow out of bit 3 and set otherwise.
// - After an addition the carry flag shows the carry out of bit 7.
// - After a subtraction the carry flag is cleared on a borrow out of bit 7 and set otherwise.
// - Rotate right loads carry with the operand LSB; rotate left with the operand MSB.
module cfs_status
(
   input  wire logic                         CLK,
   input  wire logic                         NRST,
   input  wire logic                         WDT_CAUSE,
   input  wire logic                         BOR_CAUSE,
   input  wire cfs_pkg::cfs_op_t             ALU_OP,
   input  wire logic [7:0]                   ALU_A,
   input  wire logic [7:0]                   ALU_B,
   input  wire logic                         ALU_CIN,
   input  wire logic [7:0]                   ALU_RES,
   input  wire logic                         ZERO_EN,
   input  wire logic                         PAGE_WR,
   input  wire logic [2:0]                   PAGE_VAL,
   input  wire logic [cfs_pkg::JADDR_W-1:0]  JUMP_ADDR,
   output logic      [cfs_pkg::TADDR_W-1:0]  TARGET_ADDR,
   output logic      [7:0]                   FLAGS,
   input  wire logic [7:0]                   ADDR,
   input  wire logic [7:0]                   WDATA,
   input  wire logic                         WR,
   input  wire logic                         RD,
   output logic      [7:0]                   RDATA,
   output logic                              IRQ
);
   import cfs_pkg::*;

   typedef struct packed
   {
      logic [2:0]          page;
      logic                wd;
      logic                bo;
      logic                z;
      logic                dc;
      logic                c;
      logic [EV_W-1:0]     ist;
      logic [EV_W-1:0]     imask;
      logic [7:0]          rdata;
      logic [TADDR_W-1:0]  target;
      logic                irq;
   } cfs_state_t;

   cfs_state_t         s_q;
   cfs_state_t         s_d;
   logic [8:0]         sum_w;
   logic               nib_w;
   logic [8:0]         nsum_w;
   logic [7:0]         opb_w;
   logic [EV_W-1:0]    ev_w;
   logic [EV_W-1:0]    clr_w;

   // one adder serves add and subtract; subtract feeds the inverted
   // operand so the carry out is already the "no borrow" sense
   function automatic logic [8:0] add9
   (
      input logic [7:0] a,
      input logic [7:0] b,
      input logic       cin
   );
      add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
   endfunction

   function automatic logic [7:0] flag_byte(input cfs_state_t st);
      logic [7:0] v;
      v                      = 8'h00;
      v[PAGE_LSB+2:PAGE_LSB] = st.page;
      v[WD_BIT]              = st.wd;
      v[BO_BIT]              = st.bo;
      v[Z_BIT]               = st.z;
      v[DC_BIT]              = st.dc;
      v[C_BIT]               = st.c;
      flag_byte              = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////

   always_comb
   begin
      opb_w = (ALU_OP == OP_SUB) ? ~ALU_B : ALU_B;
      sum_w = add9(ALU_A, opb_w, ALU_CIN);
      // low nibbles alone through the same adder: bit 4 is the digit carry
      nsum_w = add9({4'h0, ALU_A[3:0]}, {4'h0, opb_w[3:0]}, ALU_CIN);
      nib_w  = nsum_w[4];
   end

   always_comb
   begin
      s_d   = s_q;
      ev_w  = '0;
      clr_w = '0;

      // software side: cause flags are read-only on purpose
      if (WR && ADDR == OFS_FLAGS)
      begin
         s_d.page = WDATA[PAGE_LSB+2:PAGE_LSB];
         s_d.z    = WDATA[Z_BIT];
         s_d.dc   = WDATA[DC_BIT];
         s_d.c    = WDATA[C_BIT];
      end
      if (WR && ADDR == OFS_IMASK)
      begin
         s_d.imask = WDATA[EV_W-1:0];
      end
      if (WR && ADDR == OFS_ISTAT)
      begin
         clr_w = WDATA[EV_W-1:0];
      end

      // instruction side wins over a software write in the same cycle
      if (PAGE_WR)
      begin
         s_d.page      = PAGE_VAL;
         ev_w[EV_PAGE] = 1'b1;
      end

      unique case (ALU_OP)
         OP_ADD, OP_SUB:
         begin
            s_d.c  = sum_w[8];
            s_d.dc = nib_w;
         end
         OP_RR:
         begin
            s_d.c = ALU_A[0];
         end
         OP_RL:
         begin
            s_d.c = ALU_A[7];
         end
         OP_NONE, OP_LOGIC:
         begin
            s_d.c = s_d.c;
         end
      endcase
      if (ALU_OP inside {OP_ADD, OP_SUB, OP_RR, OP_RL})
      begin
         ev_w[EV_CARRY] = s_d.c;
      end

      if (ZERO_EN)
      begin
         s_d.z          = (ALU_RES == 8'h00);
         ev_w[EV_ZERO]  = (ALU_RES == 8'h00);
      end

      // set beats write-one-to-clear
      s_d.ist = (s_q.ist & ~clr_w) | ev_w;

      // wd/bo never assigned here outside reset
      s_d.target = {s_q.page, JUMP_ADDR};

      s_d.rdata = RDATA_RST;
      if (RD)
      begin
         unique case (ADDR)
            OFS_FLAGS: s_d.rdata = flag_byte(s_q);
            OFS_ISTAT: s_d.rdata = {5'h00, s_q.ist};
            OFS_IMASK: s_d.rdata = {5'h00, s_q.imask};
            default:   s_d.rdata = RDATA_RST;
         endcase
      end

      s_d.irq = |(s_d.ist & s_d.imask);

      // synchronous reset: the cause inputs are sampled on the edge
      if (!NRST)
      begin
         s_d.page   = PAGE_RST;
         s_d.wd     = WDT_CAUSE;
         s_d.bo     = BOR_CAUSE;
         s_d.z      = 1'b0;
         s_d.dc     = 1'b0;
         s_d.c      = 1'b0;
         s_d.ist    = EVT_RST;
         s_d.imask  = EVT_RST;
         s_d.rdata  = RDATA_RST;
         s_d.target = TADDR_RST;
         s_d.irq    = 1'b0;
      end
   end

   always_ff @(posedge CLK)
   begin
      s_q <= s_d;
   end

   assign TARGET_ADDR = s_q.target;
   assign FLAGS       = flag_byte(s_q);
   assign RDATA       = s_q.rdata;
   assign IRQ         = s_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   logic [7:0] a_prev;
   logic       cin_prev;
   always_ff @(posedge CLK)
   begin
      a_prev   <= ALU_A;
      cin_prev <= ALU_CIN;
   end

   a_page_target: assert property
      (##1 TARGET_ADDR[15:13] == $past(FLAGS[7:5]))
      else $error("target page bits do not follow page field");
   a_page_load: assert property
      (PAGE_WR |=> FLAGS[7:5] == $past(PAGE_VAL))
      else $error("page instruction did not load page field");
   a_cause_hold: assert property
      (NRST |=> $stable(FLAGS[4:3]))
      else $error("reset cause flag moved outside reset");
   a_zero_flag: assert property
      (ZERO_EN |=> FLAGS[2] == ($past(ALU_RES) == 8'h00))
      else $error("zero flag wrong after enabled update");
   a_zero_keep: assert property
      (!ZERO_EN && !WR |=> $stable(FLAGS[2]))
      else $error("zero flag changed without enable");
   a_add_carry: assert property
      (ALU_OP == OP_ADD |=> FLAGS[0] ==
         (({1'b0, a_prev} + {1'b0, $past(ALU_B)} + {8'h00, cin_prev}) > 9'hff)
       && FLAGS[1] == (({1'b0, a_prev[3:0]} + {1'b0, $past(ALU_B[3:0])}
         + {4'h0, cin_prev}) > 5'h0f))
      else $error("add carry or nibble carry wrong");
   a_sub_borrow: assert property
      (ALU_OP == OP_SUB && ALU_CIN |=>
         FLAGS[0] == (a_prev >= $past(ALU_B))
       && FLAGS[1] == (a_prev[3:0] >= $past(ALU_B[3:0])))
      else $error("subtract borrow sense wrong");
   a_rotate_carry: assert property
      (ALU_OP inside {OP_RR, OP_RL} |=>
         FLAGS[0] == ($past(ALU_OP) == OP_RR ? a_prev[0] : a_prev[7]))
      else $error("rotate did not load carry from operand");
   a_insn_page: assert property
      (!PAGE_WR && !(WR && ADDR == OFS_FLAGS) |=> $stable(FLAGS[7:5]))
      else $error("page moved without page instruction or write");
   a_irq_level: assert property
      (##1 IRQ == |(s_q.ist & s_q.imask))
      else $error("interrupt output disagrees with status and mask");
   a_rd_data: assert property
      (RD && ADDR == OFS_IMASK |=> RDATA == {5'h00, $past(s_q.imask)})
      else $error("mask readback wrong");

   // reset checks must run while reset is low, so no disable here
   a_cause_load: assert property (disable iff (1'b0)
      !NRST |=> FLAGS[4:3] == {$past(WDT_CAUSE), $past(BOR_CAUSE)})
      else $error("reset cause flags not loaded at reset");

   // all other fields and outputs come up cleared
   a_reset_clear: assert property (disable iff (1'b0)
      !NRST |=> FLAGS[7:5] == PAGE_RST && FLAGS[2:0] == 3'h0
         && !IRQ && RDATA == RDATA_RST)
      else $error("flags or outputs not cleared at reset");

   // no stale target leaks out of reset
   a_target_rst: assert property (disable iff (1'b0)
      !NRST |=> TARGET_ADDR == TADDR_RST)
      else $error("target address not cleared at reset");

   // low part of the target is the instruction field, one cycle late
   a_target_low: assert property
      (##1 TARGET_ADDR[12:0] == $past(JUMP_ADDR))
      else $error("target low bits do not follow jump address");

   // a logic op touches only zero, never the carries
   a_logic_carry: assert property
      (ALU_OP == OP_LOGIC && !WR |=> $stable(FLAGS[1:0]))
      else $error("logic op moved a carry flag");

   // a rotate loads carry only; digit carry keeps its value
   a_rot_nibble: assert property
      (ALU_OP inside {OP_RR, OP_RL} && !WR |=> $stable(FLAGS[1]))
      else $error("rotate moved the nibble flag");

   // non-zero result with update enabled clears zero
   a_zero_clear: assert property
      (ZERO_EN && ALU_RES != 8'h00 |=> !FLAGS[2])
      else $error("zero flag not cleared on non-zero result");

   // software may not forge a reset cause
   a_cause_wr: assert property
      (WR && ADDR == OFS_FLAGS |=> $stable(FLAGS[4:3]))
      else $error("software write moved a reset cause flag");

   // a quiet cycle lets the software write land in full
   a_flags_wr: assert property
      (WR && ADDR == OFS_FLAGS && ALU_OP == OP_NONE && !ZERO_EN
         && !PAGE_WR |=> FLAGS[7:5] == $past(WDATA[7:5])
         && FLAGS[2:0] == $past(WDATA[2:0]))
      else $error("software write to flags did not land");

   // read data stand one cycle only
   a_rd_idle: assert property
      (!RD |=> RDATA == RDATA_RST)
      else $error("read data present without a read");

   // flags readback shows the byte of the read cycle
   a_rd_flags: assert property
      (RD && ADDR == OFS_FLAGS |=> RDATA == $past(FLAGS))
      else $error("flags readback wrong");

   // status readback
   a_rd_istat: assert property
      (RD && ADDR == OFS_ISTAT |=> RDATA == {5'h00, $past(s_q.ist)})
      else $error("status readback wrong");

   // holes in the map read as zero
   a_rd_hole: assert property
      (RD && ADDR > OFS_IMASK |=> RDATA == RDATA_RST)
      else $error("unmapped read not zero");

   // page instruction raises its event bit
   a_page_event: assert property
      (PAGE_WR |=> s_q.ist[EV_PAGE])
      else $error("page event not recorded");

   // zero result raises its event bit
   a_zero_event: assert property
      (ZERO_EN && ALU_RES == 8'h00 |=> s_q.ist[EV_ZERO])
      else $error("zero event not recorded");

   // write-one clears when no new event competes
   a_istat_clr: assert property
      (WR && ADDR == OFS_ISTAT && WDATA[EV_ZERO] && !ZERO_EN
         |=> !s_q.ist[EV_ZERO])
      else $error("zero event not cleared by write");

   c_add_carry: cover property (ALU_OP == OP_ADD ##1 FLAGS[0]);
   c_sub_borrow: cover property (ALU_OP == OP_SUB ##1 !FLAGS[0]);
   c_rotate: cover property (ALU_OP == OP_RL ##1 FLAGS[0]);
   c_irq: cover property (!IRQ ##1 IRQ);
   c_page: cover property (PAGE_WR ##1 FLAGS[7:5] != 3'h0);

endmodule

/* File: dv/cfs_status_tb.sv */
`timescale 1ns/10ps
module cfs_status_tb;
   import cfs_pkg::*;

   logic                clk       = 1'b0;
   logic                nrst      = 1'b0;
   logic                wdt_cause = 1'b1;
   logic                bor_cause = 1'b0;
   cfs_op_t             alu_op    = OP_NONE;
   logic [7:0]          alu_a     = 8'h00;
   logic [7:0]          alu_b     = 8'h00;
   logic                alu_cin   = 1'b0;
   logic [7:0]          alu_res   = 8'h00;
   logic                zero_en   = 1'b0;
   logic                page_wr   = 1'b0;
   logic [2:0]          page_val  = 3'h0;
   logic [JADDR_W-1:0]  jump_addr = 13'h0000;
   logic [TADDR_W-1:0]  target;
   logic [7:0]          flags;
   logic [7:0]          addr      = 8'h00;
   logic [7:0]          wdata     = 8'h00;
   logic                wr        = 1'b0;
   logic                rd        = 1'b0;
   logic [7:0]          rdata;
   logic                irq;
   int                  err_count = 0;
   int                  tests_run = 0;

   cfs_status i_dut
   (
      .CLK         (clk),
      .NRST        (nrst),
      .WDT_CAUSE   (wdt_cause),
      .BOR_CAUSE   (bor_cause),
      .ALU_OP      (alu_op),
      .ALU_A       (alu_a),
      .ALU_B       (alu_b),
      .ALU_CIN     (alu_cin),
      .ALU_RES     (alu_res),
      .ZERO_EN     (zero_en),
      .PAGE_WR     (page_wr),
      .PAGE_VAL    (page_val),
      .JUMP_ADDR   (jump_addr),
      .TARGET_ADDR (target),
      .FLAGS       (flags),
      .ADDR        (addr),
      .WDATA       (wdata),
      .WR          (wr),
      .RD          (rd),
      .RDATA       (rdata),
      .IRQ         (irq)
   );

   initial
   begin
      forever #50 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("compares %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // cause inputs only matter while reset is held
   task automatic rst(input logic w, input logic b);
      @(posedge clk);
      nrst <= 1'b0;
      wdt_cause <= w;
      bor_cause <= b;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check(flags, {3'h0, w, b, 3'h0});
   endtask

   task automatic alu(input cfs_op_t op, input logic [7:0] a,
                      input logic [7:0] b, input logic cin,
                      input logic [7:0] res, input logic zen);
      @(posedge clk);
      alu_op <= op;
      alu_a <= a;
      alu_b <= b;
      alu_cin <= cin;
      alu_res <= res;
      zero_en <= zen;
      @(posedge clk);
      alu_op <= OP_NONE;
      zero_en <= 1'b0;
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   // irq is registered on the same edge as the status bits; the task still waits two edges
   task automatic irq_is(input logic exp);
      repeat (2) @(posedge clk);
      #1;
      check({7'h00, irq}, {7'h00, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst(1'b1, 1'b0);
      alu(OP_ADD, 8'h0F, 8'h01, 1'b0, 8'h10, 1'b1);
      check(flags, 8'h12);
      alu(OP_ADD, 8'hFF, 8'h01, 1'b0, 8'h00, 1'b1);
      check(flags, 8'h17);
      alu(OP_SUB, 8'h10, 8'h01, 1'b1, 8'h0F, 1'b1);
      check(flags, 8'h11);
      alu(OP_SUB, 8'h01, 8'h02, 1'b1, 8'hFF, 1'b0);
      check(flags, 8'h10);
      $display("test add_sub done");
      alu(OP_RR, 8'h01, 8'h00, 1'b0, 8'h80, 1'b0);
      check(flags, 8'h11);
      alu(OP_RL, 8'h7F, 8'h00, 1'b0, 8'hFE, 1'b0);
      check(flags, 8'h10);
      alu(OP_RL, 8'h80, 8'h00, 1'b0, 8'h01, 1'b0);
      check(flags, 8'h11);
      alu(OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
      check(flags, 8'h15);
      alu(OP_ADD, 8'h01, 8'h01, 1'b0, 8'h02, 1'b0);
      check(flags, 8'h14);
      $display("test rotate_zero done");
      @(posedge clk);
      page_wr <= 1'b1;
      page_val <= 3'h5;
      jump_addr <= 13'h1ABC;
      @(posedge clk);
      page_wr <= 1'b0;
      #1;
      check(flags, 8'hB4);
      @(posedge clk);
      #1;
      check(target[15:8], 8'hBA);
      check(target[7:0], 8'hBC);
      $display("test page done");
      reg_wr(OFS_FLAGS, 8'hE1);
      check(flags, 8'hF1);
      reg_rd(OFS_FLAGS, 8'hF1);
      reg_rd(8'h07, 8'h00);
      reg_wr(OFS_IMASK, 8'h00);
      reg_wr(OFS_ISTAT, 8'h0F);
      reg_rd(OFS_ISTAT, 8'h00);
      alu(OP_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
      reg_rd(OFS_ISTAT, 8'h02);
      irq_is(1'b0);
      reg_wr(OFS_IMASK, 8'h02);
      irq_is(1'b1);
      reg_wr(OFS_ISTAT, 8'h02);
      irq_is(1'b0);
      $display("test registers done");
      rst(1'b0, 1'b1);
      $display("test second_reset done");
      final_report();
   end

   initial
   begin
      #200000;
      err_count++;
      final_report();
   end
endmodule
